// >>> hdl/sptrg_cfg.svh
// Register offsets, widths, mode codes, reset values and timing constants
`ifndef SPTRG_CFG_SVH
`define SPTRG_CFG_SVH

`define SPTRG_CLK_HZ          10000000
`define SPTRG_OFF_MODE        8'h00
`define SPTRG_OFF_SER_CFG     8'h04
`define SPTRG_OFF_SER_PAT     8'h08
`define SPTRG_OFF_BIT_WIDTH   8'h0C
`define SPTRG_OFF_PAT_LOGIC   8'h10
`define SPTRG_OFF_PAT_COND    8'h14
`define SPTRG_OFF_DUR_MIN     8'h18
`define SPTRG_OFF_DUR_MAX     8'h1C
`define SPTRG_OFF_STATUS      8'h20
`define SPTRG_OFF_LEVEL0      8'h24
`define SPTRG_RST_BIT_WIDTH   32'h0000_000A
`define SPTRG_RST_DUR_MIN     32'h0000_0001
`define SPTRG_RST_DUR_MAX     32'h0000_0002
`define SPTRG_RST_LEVEL       12'h800
`define SPTRG_LEVEL_W         12
`define SPTRG_PAT_LEN         6
`define SPTRG_TIME_MIN_PS     1500
`define SPTRG_RANGE_MIN_PS    10000
`define SPTRG_RANGE_MAX_PS    15000
`define SPTRG_CLK_PS          100000
`define SPTRG_MODE_SERIAL     2'h1
`define SPTRG_MODE_PATTERN    2'h2

`endif

// >>> hdl/sptrg_cfg_if.sv
// Settings carried from the register file to the matchers
`timescale 1ns/10ps
`default_nettype none
interface sptrg_cfg_if;
	import sptrg_pkg::*;
	logic [3:0]         hi_bits;
	logic [3:0]         lo_bits;
	logic [1:0]         ser_src;
	logic               ser_neg;
	logic               ser_nrz;
	logic [2:0]         ser_len;
	sptrg_sym_t [5:0]   ser_pat;
	logic [31:0]        bit_width;
	sptrg_logic_e [3:0] ch_logic;
	sptrg_cond_e        cond;
	logic               on_timeout;
	logic [31:0]        dur_min;
	logic [31:0]        dur_max;
	modport src (output hi_bits, lo_bits, ser_src, ser_neg, ser_nrz, ser_len, ser_pat, bit_width,
		ch_logic, cond, on_timeout, dur_min, dur_max);
	modport snk (input hi_bits, lo_bits, ser_src, ser_neg, ser_nrz, ser_len, ser_pat, bit_width,
		ch_logic, cond, on_timeout, dur_min, dur_max);
endinterface
`default_nettype wire

// >>> hdl/sptrg_pattern.sv
// Multi-channel logic pattern matcher with duration qualifiers
`timescale 1ns/10ps
`default_nettype none
module sptrg_pattern (
	input  wire logic     clk,
	input  wire logic     rst_n,
	input  wire logic     en,
	sptrg_cfg_if.snk      cfg,
	output logic          fire,
	output logic          pat_now
);
	import sptrg_pkg::*;
	logic [3:0]           prev_q;
	logic                 pat_q;
	logic [31:0]          dur_q;
	logic                 done_q;
	logic                 rise;
	logic                 fall;
	logic                 expire;

	function automatic logic ch_ok(input sptrg_logic_e l, input logic h, input logic lo, input logic p);
		unique case (l)
			SPTRG_LOGIC_IGNORE: ch_ok = 1'b1;
			SPTRG_LOGIC_HIGH:   ch_ok = h;
			SPTRG_LOGIC_LOW:    ch_ok = lo;
			SPTRG_LOGIC_RISE:   ch_ok = h && !p;
			SPTRG_LOGIC_FALL:   ch_ok = !h && p;
			default:            ch_ok = 1'b0;
		endcase
	endfunction

	// ----------------------------------------
	// Pattern evaluation
	// ----------------------------------------
	always_comb begin
		pat_now = 1'b1;
		for (int c = 0; c < 4; c++) begin
			pat_now = pat_now && ch_ok(cfg.ch_logic[c], cfg.hi_bits[c], cfg.lo_bits[c], prev_q[c]);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prev_q <= 4'h0;
			pat_q  <= 1'b0;
		end else begin
			prev_q <= cfg.hi_bits;
			pat_q  <= en && pat_now;
		end
	end

	assign rise = en && pat_now && !pat_q;
	assign fall = en && !pat_now && pat_q;

	// ----------------------------------------
	// Duration counting
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dur_q <= 32'h0;
		end else if (rise) begin
			dur_q <= 32'h1;
		end else if (en && pat_now && dur_q != 32'hFFFF_FFFF) begin
			dur_q <= dur_q + 32'h1;
		end
	end

	assign expire = pat_q && pat_now && (dur_q == cfg.dur_min) && !done_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_q <= 1'b0;
		end else if (rise) begin
			done_q <= 1'b0;
		end else if (expire) begin
			done_q <= 1'b1;
		end
	end

	always_comb begin
		unique case (cfg.cond)
			SPTRG_COND_ENTERED: fire = rise;
			SPTRG_COND_EXITED:  fire = fall;
			// fire on timeout or on release
			SPTRG_COND_LONGER:  fire = cfg.on_timeout ? (en && expire) : (fall && dur_q > cfg.dur_min);
			SPTRG_COND_SHORTER: fire = fall && dur_q < cfg.dur_min;
			SPTRG_COND_WINDOW:  fire = fall && dur_q > cfg.dur_min && dur_q < cfg.dur_max;
			default:            fire = 1'b0;
		endcase
	end

	a_pattern_entered: assert property (@(posedge clk) disable iff (!rst_n)
		(en && cfg.cond == SPTRG_COND_ENTERED && fire) |-> pat_now && !pat_q) else $error("entered fire bad");
	a_pattern_exited: assert property (@(posedge clk) disable iff (!rst_n)
		(en && cfg.cond == SPTRG_COND_EXITED && fire) |-> !pat_now && pat_q) else $error("exited fire bad");
	a_pattern_shorter: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg.cond == SPTRG_COND_SHORTER && fire) |-> dur_q < cfg.dur_min) else $error("shorter fire too long");
	a_pattern_window: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg.cond == SPTRG_COND_WINDOW && fire) |-> dur_q > cfg.dur_min && dur_q < cfg.dur_max)
		else $error("window fire outside range");
	a_duration_count: assert property (@(posedge clk) disable iff (!rst_n)
		rise |=> dur_q == 32'h1) else $error("duration count not restarted");
	a_ignore_all: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg.ch_logic == {4{SPTRG_LOGIC_IGNORE}}) |-> pat_now) else $error("ignored channels blocked match");
endmodule
`default_nettype wire

// >>> hdl/sptrg_pkg.sv
// Types shared by the trigger qualification block
package sptrg_pkg;
	typedef enum logic [2:0] {
		SPTRG_LOGIC_IGNORE,
		SPTRG_LOGIC_HIGH,
		SPTRG_LOGIC_LOW,
		SPTRG_LOGIC_RISE,
		SPTRG_LOGIC_FALL
	} sptrg_logic_e;
	typedef enum logic [2:0] {
		SPTRG_COND_ENTERED,
		SPTRG_COND_EXITED,
		SPTRG_COND_LONGER,
		SPTRG_COND_SHORTER,
		SPTRG_COND_WINDOW
	} sptrg_cond_e;
	typedef logic [1:0] sptrg_sym_t;
	localparam sptrg_sym_t SPTRG_SYM_ZERO = 2'h0;
	localparam sptrg_sym_t SPTRG_SYM_POS  = 2'h1;
	localparam sptrg_sym_t SPTRG_SYM_NEG  = 2'h3;
endpackage

// >>> hdl/sptrg_serial.sv
// Serial symbol pattern matcher on one selected channel
`timescale 1ns/10ps
`default_nettype none
`include "sptrg_cfg.svh"
module sptrg_serial (
	input  wire logic     clk,
	input  wire logic     rst_n,
	input  wire logic     en,
	sptrg_cfg_if.snk      cfg,
	output logic          fire
);
	import sptrg_pkg::*;
	logic                 hi_q;
	logic                 lo_q;
	logic [31:0]          cnt_q;
	sptrg_sym_t [5:0]     shf_q;
	logic                 hi_d;
	logic                 lo_d;
	logic                 tick;
	logic                 match;
	sptrg_sym_t           sym;

	// ----------------------------------------
	// Source and symbol sampling
	// ----------------------------------------
	assign hi_d = cfg.hi_bits[cfg.ser_src];
	assign lo_d = cfg.lo_bits[cfg.ser_src];
	assign tick = (cnt_q + 32'h1 >= cfg.bit_width);

	always_comb begin
		// NRZ keeps level, RZ yields signed pulses
		if (cfg.ser_nrz) begin
			sym = hi_q ? SPTRG_SYM_POS : SPTRG_SYM_ZERO;
		end else if (hi_q) begin
			sym = SPTRG_SYM_POS;
		end else if (lo_q) begin
			sym = SPTRG_SYM_NEG;
		end else begin
			sym = SPTRG_SYM_ZERO;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_q <= 1'b0;
			lo_q <= 1'b0;
		end else begin
			hi_q <= hi_d;
			lo_q <= lo_d;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= 32'h0;
		end else if (!en || tick) begin
			cnt_q <= 32'h0;
		end else begin
			cnt_q <= cnt_q + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shf_q <= '0;
		end else if (en && tick) begin
			shf_q <= {shf_q[4:0], sym};
		end
	end

	// ----------------------------------------
	// Pattern compare and slope fire
	// ----------------------------------------
	always_comb begin
		match = 1'b1;
		for (int i = 0; i < `SPTRG_PAT_LEN; i++) begin
			if (i < int'(cfg.ser_len) && shf_q[i] != cfg.ser_pat[int'(cfg.ser_len) - 1 - i]) begin
				match = 1'b0;
			end
		end
	end

	// Rising slope for positive, falling for negative
	assign fire = en && tick && match && (cfg.ser_len != 3'h0) && (cfg.ser_neg ? !hi_q : hi_q);

	a_serial_fire_tick: assert property (@(posedge clk) disable iff (!rst_n)
		fire |-> tick && en) else $error("serial fire off bit boundary");
	a_serial_shift_step: assert property (@(posedge clk) disable iff (!rst_n)
		(en && tick) |=> shf_q[0] == $past(sym)) else $error("serial shift missed symbol");
endmodule
`default_nettype wire

// >>> hdl/sptrg_top.sv
// Serial and logic pattern trigger with Wishbone register file
//
// Summary of operation
// - Serial pattern holds one to six symbols
// - Polarity picks firing slope and validates pattern
// - Coding select chooses RZ or NRZ interpretation
// - Serial source is one of four channels
// - Selected channel compared against its level
// - Programmable bit width sets symbol duration
// - Pattern channels set high, low or ignore
// - Ignored channels drop out of the match
// - Rising and falling qualifiers per channel
// - Entered fires when pattern becomes true
// - Exited fires when pattern becomes false
// - Longer-than fires on release or timeout
// - Shorter-than fires on brief pattern release
// - Window fires when duration lies between limits
// - One shared threshold level per channel
`timescale 1ns/10ps
`default_nettype none
`include "sptrg_cfg.svh"
module sptrg_top #(
	parameter int LEVEL_W = `SPTRG_LEVEL_W
) (
	input  wire logic                  sys_clk,
	input  wire logic                  resetn,
	input  wire logic                  wb_cyc_i,
	input  wire logic                  wb_stb_i,
	input  wire logic                  wb_we_i,
	input  wire logic [7:0]            wb_adr_i,
	input  wire logic [3:0]            wb_sel_i,
	input  wire logic [31:0]           wb_dat_i,
	output logic [31:0]                wb_dat_o,
	output logic                       wb_ack_o,
	output logic                       wb_err_o,
	input  wire logic [4*LEVEL_W-1:0]  ch_sample,
	output logic [3*LEVEL_W-1:0]       level_unused,
	output logic                       trig_out
);
	import sptrg_pkg::*;
	localparam logic [31:0] MIN_CYC = 32'((`SPTRG_TIME_MIN_PS + `SPTRG_CLK_PS - 1) / `SPTRG_CLK_PS);
	logic [1:0]           rst_sync_q;
	logic                 rst_n;
	logic [4*LEVEL_W-1:0] smp1_q;
	logic [4*LEVEL_W-1:0] smp2_q;
	logic [LEVEL_W-1:0]   level_q [4];
	logic [1:0]           mode_q;
	logic                 mask_seen_q;
	logic [31:0]          ser_cfg_q;
	logic [11:0]          ser_pat_q;
	logic [31:0]          bw_q;
	logic [14:0]          plog_q;
	logic [3:0]           pcond_q;
	logic [31:0]          dmin_q;
	logic [31:0]          dmax_q;
	logic                 fired_q;
	logic [31:0]          rd_d;
	logic                 hit;
	logic                 wr;
	logic                 ser_fire;
	logic                 pat_fire;
	logic                 pat_now;
	logic                 pat_valid;
	logic                 ser_en;
	sptrg_cfg_if          cfg ();

	// ----------------------------------------
	// Reset release and input synchronisers
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			smp1_q <= '0;
			smp2_q <= '0;
		end else begin
			smp1_q <= ch_sample;
			smp2_q <= smp1_q;
		end
	end

	// ----------------------------------------
	// Threshold comparators, one level each
	// ----------------------------------------
	function automatic logic above(input logic [LEVEL_W-1:0] s, input logic [LEVEL_W-1:0] l);
		above = s > l;
	endfunction

	always_comb begin
		for (int c = 0; c < 4; c++) begin
			cfg.hi_bits[c] = above(smp2_q[c*LEVEL_W +: LEVEL_W], level_q[c]);
			cfg.lo_bits[c] = above(level_q[c], smp2_q[c*LEVEL_W +: LEVEL_W]);
		end
	end

	// ----------------------------------------
	// Wishbone register file
	// ----------------------------------------
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
		merge = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				merge[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
	endfunction

	always_comb begin
		hit  = 1'b1;
		rd_d = 32'h0;
		unique case (wb_adr_i)
			`SPTRG_OFF_MODE:      rd_d = {29'h0, mask_seen_q, mode_q};
			`SPTRG_OFF_SER_CFG:   rd_d = ser_cfg_q;
			`SPTRG_OFF_SER_PAT:   rd_d = {20'h0, ser_pat_q};
			`SPTRG_OFF_BIT_WIDTH: rd_d = bw_q;
			`SPTRG_OFF_PAT_LOGIC: rd_d = {17'h0, plog_q};
			`SPTRG_OFF_PAT_COND:  rd_d = {28'h0, pcond_q};
			`SPTRG_OFF_DUR_MIN:   rd_d = dmin_q;
			`SPTRG_OFF_DUR_MAX:   rd_d = dmax_q;
			`SPTRG_OFF_STATUS:    rd_d = {28'h0, pat_valid, ser_en, pat_now, fired_q};
			default: begin
				hit = 1'b0;
				for (int c = 0; c < 4; c++) begin
					if (wb_adr_i == `SPTRG_OFF_LEVEL0 + 8'(4 * c)) begin
						hit  = 1'b1;
						rd_d = 32'(level_q[c]);
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && hit;
			wb_err_o <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && !hit;
			wb_dat_o <= rd_d;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q      <= 2'h0;
			mask_seen_q <= 1'b0;
			ser_cfg_q   <= 32'h0;
			ser_pat_q   <= 12'h0;
			bw_q        <= `SPTRG_RST_BIT_WIDTH;
			plog_q      <= 15'h0;
			pcond_q     <= 4'h0;
			dmin_q      <= `SPTRG_RST_DUR_MIN;
			dmax_q      <= `SPTRG_RST_DUR_MAX;
		end else if (wr && hit) begin
			unique case (wb_adr_i)
				`SPTRG_OFF_MODE: begin
					mode_q      <= wb_sel_i[0] ? wb_dat_i[1:0] : mode_q;
					mask_seen_q <= mask_seen_q || (wb_sel_i[0] && wb_dat_i[2]);
				end
				`SPTRG_OFF_SER_CFG:   ser_cfg_q <= merge(ser_cfg_q, wb_dat_i, wb_sel_i);
				`SPTRG_OFF_SER_PAT:   ser_pat_q <= 12'(merge({20'h0, ser_pat_q}, wb_dat_i, wb_sel_i));
				`SPTRG_OFF_BIT_WIDTH: bw_q <= merge(bw_q, wb_dat_i, wb_sel_i);
				`SPTRG_OFF_PAT_LOGIC: plog_q <= 15'(merge({17'h0, plog_q}, wb_dat_i, wb_sel_i));
				`SPTRG_OFF_PAT_COND:  pcond_q <= 4'(merge({28'h0, pcond_q}, wb_dat_i, wb_sel_i));
				`SPTRG_OFF_DUR_MIN:   dmin_q <= (wb_dat_i < MIN_CYC) ? MIN_CYC : wb_dat_i;
				`SPTRG_OFF_DUR_MAX:   dmax_q <= wb_dat_i;
				default: begin
				end
			endcase
		end
	end

	// One level per channel, shared by every mode
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int c = 0; c < 4; c++) begin
				level_q[c] <= `SPTRG_RST_LEVEL;
			end
		end else if (wr) begin
			for (int c = 0; c < 4; c++) begin
				if (wb_adr_i == `SPTRG_OFF_LEVEL0 + 8'(4 * c)) begin
					level_q[c] <= wb_dat_i[LEVEL_W-1:0];
				end
			end
		end
	end

	// ----------------------------------------
	// Serial pattern validity check
	// ----------------------------------------
	always_comb begin
		logic ok;
		ok = 1'b0;
		for (int i = 0; i < `SPTRG_PAT_LEN; i++) begin
			if (i < int'(ser_cfg_q[6:4])) begin
				if (!ser_cfg_q[3] && ser_pat_q[i*2 +: 2] == (ser_cfg_q[2] ? SPTRG_SYM_NEG : SPTRG_SYM_POS)) begin
					ok = 1'b1;
				end
				if (ser_cfg_q[3] && i > 0 && ser_pat_q[i*2 +: 2] != ser_pat_q[(i-1)*2 +: 2]
						&& ser_pat_q[i*2 +: 2] == (ser_cfg_q[2] ? SPTRG_SYM_ZERO : SPTRG_SYM_POS)) begin
					ok = 1'b1;
				end
			end
		end
		pat_valid = ok && ser_cfg_q[6:4] != 3'h0 && ser_cfg_q[6:4] <= 3'(`SPTRG_PAT_LEN);
	end

	assign ser_en = mode_q == `SPTRG_MODE_SERIAL && mask_seen_q && pat_valid;

	// ----------------------------------------
	// Settings to matchers
	// ----------------------------------------
	assign cfg.ser_src    = ser_cfg_q[1:0];
	assign cfg.ser_neg    = ser_cfg_q[2];
	assign cfg.ser_nrz    = ser_cfg_q[3];
	assign cfg.ser_len    = ser_cfg_q[6:4];
	assign cfg.bit_width  = bw_q;
	assign cfg.cond       = sptrg_cond_e'(pcond_q[2:0]);
	assign cfg.on_timeout = pcond_q[3];
	assign cfg.dur_min    = dmin_q;
	assign cfg.dur_max    = dmax_q;
	always_comb begin
		for (int i = 0; i < `SPTRG_PAT_LEN; i++) begin
			cfg.ser_pat[i] = ser_pat_q[i*2 +: 2];
		end
		for (int c = 0; c < 4; c++) begin
			cfg.ch_logic[c] = sptrg_logic_e'(plog_q[c*3 +: 3]);
		end
	end

	sptrg_serial u_serial (
		.clk   (sys_clk),
		.rst_n (rst_n),
		.en    (ser_en),
		.cfg   (cfg.snk),
		.fire  (ser_fire)
	);

	sptrg_pattern u_pattern (
		.clk     (sys_clk),
		.rst_n   (rst_n),
		.en      (mode_q == `SPTRG_MODE_PATTERN),
		.cfg     (cfg.snk),
		.fire    (pat_fire),
		.pat_now (pat_now)
	);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_out <= 1'b0;
			fired_q  <= 1'b0;
		end else begin
			trig_out <= ser_fire || pat_fire;
			fired_q  <= ser_fire || pat_fire || (fired_q && !(wr && wb_adr_i == `SPTRG_OFF_STATUS));
		end
	end

	assign level_unused = '0;

	a_serial_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ser_fire |-> mask_seen_q && mode_q == `SPTRG_MODE_SERIAL) else $error("serial fired while locked");
	a_trig_follow: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ser_fire || pat_fire) |=> trig_out) else $error("trigger output lost");

	// ----------------------------------------
	// Bus, level and status checks
	// ----------------------------------------
	sequence s_req_taken;
		wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	endsequence

	sequence s_one_answer;
		(wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o);
	endsequence

	sequence s_level1_write;
		wr && wb_adr_i == `SPTRG_OFF_LEVEL0 + 8'h04;
	endsequence

	a_bus_answer: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_req_taken |=> s_one_answer) else $error("bus answer not a single pulse");
	a_level_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		s_level1_write |=> level_q[1] == $past(wb_dat_i[LEVEL_W-1:0])) else $error("level write lost");
	a_fired_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(ser_fire || pat_fire) |=> fired_q) else $error("fired flag missed trigger");
	a_min_clamp: assert property (@(posedge sys_clk) disable iff (!rst_n)
		dmin_q >= MIN_CYC) else $error("minimum duration below floor");
endmodule
`default_nettype wire

// >>> tb/sptrg_chan_model.sv
// Thresholded analog channels feeding the four sample inputs
`timescale 1ns/10ps
`default_nettype none
module sptrg_chan_model #(
	parameter int LEVEL_W = 12
) (
	input  wire logic [3:0]           want_hi,
	input  wire logic [LEVEL_W-1:0]   swing,
	output logic [4*LEVEL_W-1:0]      ch_sample
);
	localparam logic [LEVEL_W-1:0] MID = LEVEL_W'(1) << (LEVEL_W - 1);
	// Each channel sits one swing above or below mid scale
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			ch_sample[c*LEVEL_W +: LEVEL_W] = want_hi[c] ? MID + swing : MID - swing;
		end
	end
endmodule
`default_nettype wire

// >>> tb/tb.sv
// Self-checking bench for the serial and pattern trigger
`timescale 1ns/10ps
`default_nettype none
`include "sptrg_cfg.svh"
module tb;
	logic         sys_clk = 1'b0;
	logic         resetn;
	logic         wb_cyc_i, wb_stb_i, wb_we_i;
	logic [7:0]   wb_adr_i;
	logic [3:0]   wb_sel_i;
	logic [31:0]  wb_dat_i, wb_dat_o, rdat, r;
	logic         wb_ack_o, wb_err_o, rerr, trig_out;
	logic [47:0]  ch_sample;
	logic [35:0]  level_unused;
	logic [3:0]   want_hi;
	logic [11:0]  swing;
	logic [31:0]  rng = 32'h1A;
	int           n_fail = 0, n_checks = 0, n_trig = 0, got, len;
	logic [31:0]  s_cfg [7] = '{32'h2A, 32'h2A, 32'h2E, 32'h28, 32'h22, 32'h26, 32'h22};
	logic [31:0]  s_pat [7] = '{32'h004, 32'h005, 32'h001, 32'h004, 32'h007, 32'h00D, 32'h00F};
	int           s_exp [7] = '{1, 0, 1, 0, 1, 1, 0};
	int           s_ok [7] = '{1, 0, 1, 1, 1, 1, 0};
	int           lens [3] = '{2, 10, 30};

	always #50 sys_clk = ~sys_clk;
	always @(posedge sys_clk) if (trig_out === 1'b1) n_trig <= n_trig + 1;

	sptrg_top dut_u (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .ch_sample(ch_sample),
		.level_unused(level_unused), .trig_out(trig_out));
	sptrg_chan_model chan_u (.want_hi(want_hi), .swing(swing), .ch_sample(ch_sample));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic rnd(output logic [31:0] v);
		rng = xs(rng);
		v = rng;
	endtask
	function automatic int exp_trig(input logic [2:0] c, input int n);
		case (c)
			3'h2: return (n > 5) ? 1 : 0;
			3'h3: return (n < 5) ? 1 : 0;
			3'h4: return (n > 5 && n < 15) ? 1 : 0;
			default: return 1;
		endcase
	endfunction
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_sel_i <= 4'hF;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge sys_clk);
			k++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 50);
		if (k >= 50) chk("wb_answer", 32'h1, 32'h0);
		rdat = wb_dat_o;
		rerr = wb_err_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(name, exp, rdat & m);
	endtask
	task automatic pulse(input int n, output int cnt);
		int t0;
		logic [31:0] v;
		want_hi <= 4'h0;
		repeat (12) @(posedge sys_clk);
		t0 = n_trig;
		for (int i = 0; i < n; i++) begin
			rnd(v);
			want_hi <= {v[1:0], 2'b01};
			@(posedge sys_clk);
		end
		want_hi <= 4'h0;
		repeat (12) @(posedge sys_clk);
		cnt = n_trig - t0;
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_fail++;
		conclude();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		resetn = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'hF;
		wb_dat_i = 32'h0;
		want_hi = 4'h0;
		swing = 12'h100;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd_chk("bit_width", `SPTRG_OFF_BIT_WIDTH, 32'hFFFFFFFF, `SPTRG_RST_BIT_WIDTH);
		rd_chk("dur_min", `SPTRG_OFF_DUR_MIN, 32'hFFFFFFFF, `SPTRG_RST_DUR_MIN);
		rd_chk("dur_max", `SPTRG_OFF_DUR_MAX, 32'hFFFFFFFF, `SPTRG_RST_DUR_MAX);
		for (int c = 0; c < 4; c++) rd_chk("level", 8'(`SPTRG_OFF_LEVEL0 + 4 * c), 32'hFFF, 32'(`SPTRG_RST_LEVEL));
		rnd(r);
		wb(1'b1, `SPTRG_OFF_LEVEL0 + 8'h04, {20'h0, r[11:0]});
		rd_chk("level_wr", `SPTRG_OFF_LEVEL0 + 8'h04, 32'hFFF, {20'h0, r[11:0]});
		wb(1'b1, `SPTRG_OFF_LEVEL0 + 8'h04, 32'(`SPTRG_RST_LEVEL));
		wb(1'b0, 8'hFC, 32'h0);
		chk("unmapped_err", 32'h1, {31'h0, rerr});
		wb(1'b1, `SPTRG_OFF_DUR_MIN, 32'h0);
		rd_chk("dur_floor", `SPTRG_OFF_DUR_MIN, 32'hFFFFFFFF, 32'h1);
		chk("level_unused", 32'h0, {31'h0, |level_unused});
		$display("test registers done");

		wb(1'b1, `SPTRG_OFF_MODE, 32'h6);
		wb(1'b1, `SPTRG_OFF_PAT_LOGIC, 32'h11);
		wb(1'b1, `SPTRG_OFF_DUR_MIN, 32'h5);
		wb(1'b1, `SPTRG_OFF_DUR_MAX, 32'hF);
		rnd(r);
		swing <= 12'h001 + {1'b0, r[10:0]} % 12'h7FE;
		want_hi <= 4'h1;
		repeat (6) @(posedge sys_clk);
		rd_chk("pattern_true", `SPTRG_OFF_STATUS, 32'h2, 32'h2);
		want_hi <= 4'h3;
		repeat (6) @(posedge sys_clk);
		rd_chk("pattern_false", `SPTRG_OFF_STATUS, 32'h2, 32'h0);
		for (int c = 0; c < 2; c++) begin
			wb(1'b1, `SPTRG_OFF_PAT_COND, 32'(c));
			pulse(10, got);
			chk("enter_exit", 32'h1, 32'(got));
		end
		for (int k = 0; k < 9; k++) begin
			rnd(r);
			len = lens[(k % 3 == 2) ? r % 3 : 2 * (r % 2)];
			wb(1'b1, `SPTRG_OFF_PAT_COND, (k % 3 == 0) ? ((k == 3) ? 32'h2 : 32'hA) : 32'(k % 3 + 2));
			pulse(len, got);
			chk("duration", 32'(exp_trig(3'(k % 3 + 2), len)), 32'(got));
		end
		wb(1'b1, `SPTRG_OFF_PAT_COND, 32'h0);
		for (int c = 3; c < 5; c++) begin
			wb(1'b1, `SPTRG_OFF_PAT_LOGIC, 32'(c));
			pulse(10, got);
			chk("edge_qual", 32'h1, 32'(got));
		end
		rd_chk("fired", `SPTRG_OFF_STATUS, 32'h1, 32'h1);
		wb(1'b1, `SPTRG_OFF_STATUS, 32'h0);
		rd_chk("fired_clear", `SPTRG_OFF_STATUS, 32'h1, 32'h0);
		$display("test pattern done");

		wb(1'b1, `SPTRG_OFF_MODE, 32'h5);
		wb(1'b1, `SPTRG_OFF_BIT_WIDTH, 32'h4);
		for (int i = 0; i < 7; i++) begin
			wb(1'b1, `SPTRG_OFF_SER_CFG, s_cfg[i]);
			wb(1'b1, `SPTRG_OFF_SER_PAT, s_pat[i]);
			rd_chk("ser_valid", `SPTRG_OFF_STATUS, 32'hC, (s_ok[i] != 0) ? 32'hC : 32'h0);
			got = n_trig;
			want_hi <= 4'h0;
			repeat (40) @(posedge sys_clk);
			want_hi <= 4'h4;
			repeat (40) @(posedge sys_clk);
			want_hi <= 4'h0;
			repeat (40) @(posedge sys_clk);
			chk("serial_trig", 32'(s_exp[i]), 32'(n_trig - got));
		end
		$display("test serial done");
		conclude();
	end
endmodule
`default_nettype wire
